// [core/ram_part_pkg.sv]
// package for the data RAM partition register block
// assumes a plain strobe register port with 32-bit data
package ram_part_pkg;
    // register map, byte addresses
    localparam logic [7:0]  USER_DATA_BASE_OFS = 8'h00;
    localparam logic [7:0]  USER_PROG_BASE_OFS = 8'h04;
    localparam logic [7:0]  KERNEL_PROG_BASE_OFS = 8'h08;
    localparam logic [7:0]  RAM_SIZE_OFS       = 8'h0C;
    localparam logic [7:0]  CLASS_QUERY_OFS    = 8'h10;
    // base field layout
    localparam int          BASE_LSB           = 10;
    localparam int          BASE_MSB           = 15;
    localparam int          BASE_W             = BASE_MSB - BASE_LSB + 1;
    localparam logic [BASE_W-1:0] BASE_RESET   = 6'h00;
    // class query register layout: offset in 15:0, class in 17:16
    localparam int          QUERY_OFS_W        = 16;
    localparam int          CLASS_LSB          = 16;
    // default ram size value in bytes, 32 KB
    localparam logic [15:0] RAM_SIZE_DEFAULT   = 16'h8000;

    typedef enum logic [1:0] {
        KERNEL_DATA,
        KERNEL_PROG,
        USER_DATA,
        USER_PROG
    } space_t;

    // boundaries handed to the classifier
    typedef struct packed {
        logic [15:0] kernelProgBase;
        logic [15:0] userDataBase;
        logic [15:0] userProgBase;
        logic [15:0] ramSize;
    } bounds_t;
endpackage

// [core/ram_space_classify.sv]
// classifier: maps a data RAM offset onto one of four spaces
// assumes bounds come from registers on the same clock
`timescale 1ns/100ps
module ram_space_classify (
    // boundaries
    input  wire ram_part_pkg::bounds_t bounds,
    // offset to classify
    input  wire logic [15:0]           offset,
    // result
    output ram_part_pkg::space_t       space
);
    logic userDataOn;
    logic userProgOn;

    // zero base means that region is absent
    always_comb begin
        userDataOn = (bounds.userDataBase != 16'h0000);
        userProgOn = (bounds.userProgBase != 16'h0000);
        if (userProgOn && offset >= bounds.userProgBase) begin
            space = ram_part_pkg::USER_PROG;
        end else if (userDataOn && offset >= bounds.userDataBase) begin
            space = ram_part_pkg::USER_DATA;
        end else if (bounds.kernelProgBase != 16'h0000
                     && offset >= bounds.kernelProgBase) begin
            space = ram_part_pkg::KERNEL_PROG;
        end else begin
            space = ram_part_pkg::KERNEL_DATA;
        end
    end
endmodule

// [core/ram_user_partition_regs.sv]
// partition registers splitting data RAM into kernel and user spaces
// assumes a single-clock strobe register port, read data one cycle later
// assumes software keeps the ordering limits between the bases
//
// Contract
// - user data base holds a writable 6-bit field at bits 15..10
// - bits 9..0 of both registers read zero, giving 1 KB steps
// - reset clears both registers, all RAM is kernel data
// - user program base holds a writable 6-bit field at bits 15..10
// - bits 31..16 of both registers read zero and ignore writes
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module ram_user_partition_regs #(
    parameter logic [15:0] RAM_SIZE = ram_part_pkg::RAM_SIZE_DEFAULT
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdata,
    // boundaries for the RAM arbiter
    output logic [15:0]      userDataBase,
    output logic [15:0]      userProgBase,
    // classification of the queried offset
    output logic [1:0]       spaceClass
);
    localparam int L = ram_part_pkg::BASE_LSB;
    localparam int M = ram_part_pkg::BASE_MSB;

    logic [ram_part_pkg::BASE_W-1:0] udBase_q, udBase_d;
    logic [ram_part_pkg::BASE_W-1:0] upBase_q, upBase_d;
    logic [ram_part_pkg::BASE_W-1:0] kpBase_q, kpBase_d;
    logic [15:0]                     query_q, query_d;
    logic [31:0]                     rdata_q, rdata_d;
    logic [1:0]                      class_q, class_d;
    ram_part_pkg::bounds_t           bounds;
    ram_part_pkg::space_t            space;
    // address decode, write enables and write field
    logic                            selUserData;
    logic                            selUserProg;
    logic                            selKernProg;
    logic                            selRamSize;
    logic                            selQuery;
    logic                            wrUserData;
    logic                            wrUserProg;
    logic                            wrKernProg;
    logic                            wrQuery;
    logic [ram_part_pkg::BASE_W-1:0] wrField;
    // read words as they appear on the bus
    logic [31:0]                     udWord;
    logic [31:0]                     upWord;
    logic [31:0]                     kpWord;
    logic [31:0]                     sizeWord;
    logic [31:0]                     queryWord;

    // full addresses with the fixed zero low bits
    always_comb begin
        bounds.kernelProgBase = {kpBase_q, 10'h000};
        bounds.userDataBase   = {udBase_q, 10'h000};
        bounds.userProgBase   = {upBase_q, 10'h000};
        bounds.ramSize        = RAM_SIZE;
    end

    // classifier sees registered bounds, so its answer settles in one cycle
    ram_space_classify classify (
        .bounds (bounds),
        .offset (query_q),
        .space  (space)
    );

    // address decode; one select per word of the map
    always_comb begin
        selUserData = (regAddr == ram_part_pkg::USER_DATA_BASE_OFS);
        selUserProg = (regAddr == ram_part_pkg::USER_PROG_BASE_OFS);
        selKernProg = (regAddr == ram_part_pkg::KERNEL_PROG_BASE_OFS);
        selRamSize  = (regAddr == ram_part_pkg::RAM_SIZE_OFS);
        selQuery    = (regAddr == ram_part_pkg::CLASS_QUERY_OFS);
    end

    // write enables; the ram size word has none, so writes there are lost
    always_comb begin
        wrUserData = regWrite && selUserData;
        wrUserProg = regWrite && selUserProg;
        wrKernProg = regWrite && selKernProg;
        wrQuery    = regWrite && selQuery;
    end

    // only bits 15..10 are kept, the rest of the word is dropped
    always_comb begin
        wrField = regWdata[M:L];
    end

    // user data base; ordering against kernel base is left to software
    always_comb begin
        udBase_d = udBase_q;
        if (wrUserData) begin
            udBase_d = wrField;
        end
    end

    // reset hands all RAM to kernel data
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            udBase_q <= ram_part_pkg::BASE_RESET;
        end else begin
            udBase_q <= udBase_d;
        end
    end

    // user program base; not clamped against the user data base
    always_comb begin
        upBase_d = upBase_q;
        if (wrUserProg) begin
            upBase_d = wrField;
        end
    end

    // cleared together with the user data base
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            upBase_q <= ram_part_pkg::BASE_RESET;
        end else begin
            upBase_q <= upBase_d;
        end
    end

    // kernel program base, held here so all bounds sit in one place
    always_comb begin
        kpBase_d = kpBase_q;
        if (wrKernProg) begin
            kpBase_d = wrField;
        end
    end

    // zero kernel base means no kernel program space
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            kpBase_q <= ram_part_pkg::BASE_RESET;
        end else begin
            kpBase_q <= kpBase_d;
        end
    end

    // query offset, read back beside its class
    always_comb begin
        query_d = query_q;
        if (wrQuery) begin
            query_d = regWdata[ram_part_pkg::QUERY_OFS_W-1:0];
        end
    end

    // query restarts at offset zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            query_q <= 16'h0000;
        end else begin
            query_q <= query_d;
        end
    end

    // class registered so the output comes from a flop; costs one cycle
    always_comb begin
        class_d = space;
    end

    // after reset the class is kernel data
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            class_q <= 2'h0;
        end else begin
            class_q <= class_d;
        end
    end

    // read words; base words keep low ten bits and upper half at zero, query word carries offset and class
    always_comb begin
        udWord    = 32'h0000_0000;
        upWord    = 32'h0000_0000;
        kpWord    = 32'h0000_0000;
        sizeWord  = 32'h0000_0000;
        queryWord = 32'h0000_0000;
        udWord[M:L] = udBase_q;
        upWord[M:L] = upBase_q;
        kpWord[M:L] = kpBase_q;
        sizeWord[15:0] = bounds.ramSize;
        queryWord[ram_part_pkg::QUERY_OFS_W-1:0] = query_q;
        queryWord[ram_part_pkg::CLASS_LSB +: 2] = class_q;
    end

    // read mux; idle cycles and unmapped reads give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (regRead) begin
            if (selUserData) begin
                rdata_d = udWord;
            end else if (selUserProg) begin
                rdata_d = upWord;
            end else if (selKernProg) begin
                rdata_d = kpWord;
            end else if (selRamSize) begin
                rdata_d = sizeWord;
            end else if (selQuery) begin
                rdata_d = queryWord;
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // read data stands one cycle only, then falls back to zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // outputs straight from flops
    assign regRdata     = rdata_q;
    assign userDataBase = bounds.userDataBase;
    assign userProgBase = bounds.userProgBase;
    assign spaceClass   = class_q;
endmodule

// [test/ram_user_partition_regs_asserts.sv]
// checker for the partition register block
// sees only the top ports; bound from the foot of this file
`timescale 1ns/100ps
module ram_user_partition_regs_asserts (
    // watched ports
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic [15:0] userDataBase,
    input wire logic [15:0] userProgBase,
    input wire logic [1:0]  spaceClass
);
    logic [5:0]             wField;
    // field bits of the write word, so $past sees a plain signal
    assign wField = regWdata[15:10];
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // a base write lands the field only, next cycle
    a_udb_write: assert property (regWrite && regAddr == 8'h00 |=>
        userDataBase == {$past(wField), 10'h000}) else $error("udb write");
    a_upb_write: assert property (regWrite && regAddr == 8'h04 |=>
        userProgBase == {$past(wField), 10'h000}) else $error("upb write");
    a_low_zero: assert property (userDataBase[9:0] == 10'h000 &&
        userProgBase[9:0] == 10'h000) else $error("low bits set");
    a_reset_zero: assert property ($rose(nrst) |->
        userDataBase == 16'h0000 && userProgBase == 16'h0000) else $error("reset value");
    // read data of a base shows the held value with a zero upper half
    a_read_back: assert property (regRead && regAddr == 8'h00 |=>
        regRdata == {16'h0000, userDataBase}) else $error("udb read");
    a_upb_read: assert property (regRead && regAddr == 8'h04 |=>
        regRdata == {16'h0000, userProgBase}) else $error("upb read");
    // base words on the bus keep their pad bits at zero
    a_rdata_pad: assert property (regRead && (regAddr == 8'h00 || regAddr == 8'h04) |=>
        regRdata[31:16] == 16'h0000 && regRdata[9:0] == 10'h000) else $error("read pad set");
    // class may only move after a register write
    a_class_hold: assert property (!regWrite [*3] |-> $stable(spaceClass))
        else $error("class moved");
    c_udb: cover property (regWrite && regAddr == 8'h00);
    c_query: cover property (regWrite && regAddr == 8'h10);
    c_uprog: cover property (spaceClass == 2'h3);
endmodule
bind ram_user_partition_regs ram_user_partition_regs_asserts chk (.mclk(mclk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .userDataBase(userDataBase), .userProgBase(userProgBase),
    .spaceClass(spaceClass));

// [test/reg_sw_master.sv]
// software side model: issues register writes and reads
// assumes the block answers reads one cycle later, never stalls
`timescale 1ns/100ps
module reg_sw_master (
    // clock
    input wire logic         mclk,
    // register port
    output logic [7:0]       regAddr,
    output logic [31:0]      regWdata,
    output logic             regWrite,
    output logic             regRead,
    input wire logic [31:0]  regRdata
);
    initial begin
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(posedge mclk);
        d = regRdata;
    endtask
endmodule

// [test/ram_user_partition_regs_test.sv]
// self-checking bench for the partition registers
// assumes the software model drives the register port
`timescale 1ns/100ps
module ram_user_partition_regs_test;
    logic        mclk;
    logic        nrst;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, got;
    logic        regWrite, regRead;
    logic [15:0] userDataBase, userProgBase;
    logic [1:0]  spaceClass;
    int          failures = 0;
    int          checks = 0;
    reg_sw_master sw (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    ram_user_partition_regs dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .userDataBase(userDataBase), .userProgBase(userProgBase), .spaceClass(spaceClass));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // all ones written: only the 1 KB field survives
    task automatic t_fields;
        sw.rd(8'h00, got);
        chk(got, 32'h0000_0000);
        sw.wr(8'h00, 32'hFFFF_FFFF);
        sw.rd(8'h00, got);
        chk(got, 32'h0000_FC00);
        sw.wr(8'h04, 32'hFFFF_FFFF);
        sw.rd(8'h04, got);
        chk(got, 32'h0000_FC00);
        sw.wr(8'h00, 32'hFFFF_03FF);
        sw.rd(8'h00, got);
        chk(got, 32'h0000_0000);
        sw.rd(8'h20, got);
        chk(got, 32'h0000_0000);
    endtask
    // one offset per space, bases in legal order below the ram size
    task automatic t_class;
        logic [15:0] ofs [4] = '{16'h0000, 16'h1000, 16'h2000, 16'h7C00};
        sw.wr(8'h08, 32'h0000_1000);
        sw.wr(8'h00, 32'h0000_2000);
        sw.wr(8'h04, 32'h0000_4000);
        for (int i = 0; i < 4; i++) begin
            sw.wr(8'h10, {16'h0000, ofs[i]});
            sw.rd(8'h10, got);
            chk(got, {14'h0000, i[1:0], ofs[i]});
            chk({30'h0, spaceClass}, {30'h0, i[1:0]});
        end
        chk({16'h0000, userDataBase}, 32'h0000_2000);
        chk({16'h0000, userProgBase}, 32'h0000_4000);
        sw.rd(8'h08, got);
        chk(got, 32'h0000_1000);
        sw.wr(8'h0C, 32'h0000_0000);
        sw.rd(8'h0C, got);
        chk(got, {16'h0000, ram_part_pkg::RAM_SIZE_DEFAULT});
    endtask
    // reset in mid-run clears the bases left set by t_class
    task automatic t_reset;
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        sw.rd(8'h00, got);
        chk(got, 32'h0000_0000);
        sw.rd(8'h04, got);
        chk(got, 32'h0000_0000);
        sw.wr(8'h10, 32'h0000_7C00);
        sw.rd(8'h10, got);
        chk(got, 32'h0000_7C00);
    endtask
    // watchdog well beyond the fewer than 100 cycles needed
    initial begin
        #20000;
        failures++;
        results();
    end
    initial begin
        nrst = 1'b0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_fields();
        t_class();
        t_reset();
        results();
    end
endmodule
